// ===== verilog/tivb_map.vh
`ifndef TIVB_MAP_VH
`define TIVB_MAP_VH
// Byte offsets, one aligned word each; 64-bit registers take two words
`define TIVB_OFF_SMVAL_LO   12'h000
`define TIVB_OFF_SMVAL_HI   12'h004
`define TIVB_OFF_SMVA_LO    12'h008
`define TIVB_OFF_SMVA_HI    12'h00c
`define TIVB_OFF_HVA_N      12'h010
`define TIVB_OFF_HVA_W_LO   12'h018
`define TIVB_OFF_HVA_W_HI   12'h01c
`define TIVB_OFF_CFG        12'h020
`define TIVB_OFF_STAT       12'h024
// Configuration register fields
`define TIVB_CFG_GRAN64     0
`define TIVB_CFG_NARROW     1
`define TIVB_CFG_RESET      2'h0
// Address field layout
`define TIVB_VA_MSB         55
`define TIVB_PAGE_LSB       12
`define TIVB_G64_MSB        15
`define TIVB_HI_FLD_MSB     11
`define TIVB_N_RSV_MSB      11
`define TIVB_NARROW_TOP     31
// Entry counts
`define TIVB_ENTRIES        16
`define TIVB_IDX_W          4
`define TIVB_TAG_W          44
// Context kinds of an entry
`define TIVB_CTX_SECURE_MONITOR_CONTEXT       2'h1
`define TIVB_CTX_HYP        2'h2
`endif

// ===== verilog/tivb_top.v
// What this block does
// - Last-level monitor write removes unlocked monitor entries matching address, final level.
// - Monitor write removes unlocked monitor entries matching address, any level.
// - Lone low-word write acts as full write, upper word zero.
// - Lone upper-word write does nothing, no invalidation.
// - Over-invalidation allowed; locked entries are never removed.
// - Monitor and wide hypervisor registers absent in first architecture version.
// - With one security state, monitor registers are reserved, no invalidation.
// - Wide register bits 63:44 reserved, 43:0 carry address 55:12.
// - With 64KB granule, address bits 15:12 are ignored in matching.
// - Address bit 55 is copied into bits 63:56.
// - Wide hypervisor register under narrow schemes treats bits 55:32 as zero.
// - Narrow hypervisor register takes address 31:12; bits 11:0 reserved.
// - No narrow scheme support: narrow register reads zero, ignores writes.
// - Hypervisor writes remove unlocked hypervisor entries matching address.
// - All four registers write-only; three are 64 bits wide.
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "tivb_map.vh"
module tivb_top #(
  parameter FIRST_VERSION = 1'b0,   // Register set of first architecture
  parameter TWO_SECURITY  = 1'b1,   // Two security states built
  parameter NARROW_SCHEME = 1'b1    // Narrow translation schemes built
) (
  input  wire        CLK_SYS_I,                  // System clock 25 MHz
  input  wire        ARST_N_I,                   // Async reset, low
  input  wire        PSEL_I,                     // APB select
  input  wire        PENABLE_I,                  // APB enable
  input  wire        PWRITE_I,                   // APB direction
  input  wire [11:0] PADDR_I,                    // APB byte address
  input  wire [31:0] PWDATA_I,                   // APB write data
  output wire        PREADY_O,                   // APB ready
  output reg  [31:0] PRDATA_O,                   // APB read data
  output reg         PSLVERR_O,                  // APB error
  input  wire        FILL_I,                     // Allocate an entry
  input  wire [63:0] FILL_VA_I,                  // Entry virtual address
  input  wire [1:0]  FILL_CTX_I,                 // Entry context kind
  input  wire        FILL_LAST_I,                // Entry from final level
  input  wire        FILL_LOCK_I,                // Entry locked
  input  wire [`TIVB_IDX_W-1:0] FILL_IDX_I,      // Entry slot
  output reg  [`TIVB_ENTRIES-1:0] VALID_O,       // Entry valid bits
  output reg         INVAL_O                     // Invalidation pulse
);
  reg        rst_s1_q;
  reg        rst_n_q;
  reg [1:0]  cfg_q;
  reg [31:0] lo_q [0:2];
  reg [2:0]  lo_pend_q;
  reg [7:0]  stat_q;
  reg [63:0] tag_va_q [0:`TIVB_ENTRIES-1];
  reg [1:0]  tag_ctx_q [0:`TIVB_ENTRIES-1];
  reg [`TIVB_ENTRIES-1:0] tag_last_q;
  reg [`TIVB_ENTRIES-1:0] tag_lock_q;

  reg        op_go;
  reg [1:0]  op_ctx;
  reg        op_last;
  reg [63:0] op_va;
  reg        op_narrow;
  reg        mapped;
  reg [1:0]  wide_sel;
  reg        wide_hi;
  reg [2:0]  wide_code;
  reg        ack_q;
  // Slots of the three wide registers in the pairing store
  localparam [1:0] SLOT_SMVAL = 2'h0;
  localparam [1:0] SLOT_SMVA  = 2'h1;
  localparam [1:0] SLOT_HVA_W = 2'h2;
  localparam [1:0] SLOT_NONE  = 2'h3;
  // A write acts only at the edge that completes the transfer
  wire       acc       = PSEL_I && PENABLE_I;
  wire       acc_first = acc && !ack_q;
  wire       wr        = acc && ack_q && PWRITE_I;
  wire       rd        = acc_first && !PWRITE_I;
  wire       mon_ok  = !FIRST_VERSION && TWO_SECURITY;
  wire       hw_ok   = !FIRST_VERSION;
  wire [`TIVB_ENTRIES-1:0] hit;

  // Read data and error are flops, so every access waits one cycle
  assign PREADY_O = ack_q;

  always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // Sign-extend a 44-bit page field, optionally zeroing its top 24 bits (43:20)
  function [63:0] tivb_mk_va;
    input [`TIVB_TAG_W-1:0] fld;
    input                   narrow;
    reg   [`TIVB_TAG_W-1:0] f;
    begin
      f = fld;
      if (narrow)
        f[`TIVB_TAG_W-1:`TIVB_NARROW_TOP-`TIVB_PAGE_LSB+1] =
          {(`TIVB_TAG_W-`TIVB_NARROW_TOP+`TIVB_PAGE_LSB-1){1'b0}};
      tivb_mk_va = {{8{f[`TIVB_TAG_W-1]}}, f,
                    {`TIVB_PAGE_LSB{1'b0}}};
    end
  endfunction

  // Which wide register (0..2) an offset names, and whether it is upper
  function [2:0] tivb_wide;
    input [11:0] a;
    begin
      case (a)
        `TIVB_OFF_SMVAL_LO: tivb_wide = {SLOT_SMVAL, 1'b0};
        `TIVB_OFF_SMVAL_HI: tivb_wide = {SLOT_SMVAL, 1'b1};
        `TIVB_OFF_SMVA_LO:  tivb_wide = {SLOT_SMVA, 1'b0};
        `TIVB_OFF_SMVA_HI:  tivb_wide = {SLOT_SMVA, 1'b1};
        `TIVB_OFF_HVA_W_LO: tivb_wide = {SLOT_HVA_W, 1'b0};
        `TIVB_OFF_HVA_W_HI: tivb_wide = {SLOT_HVA_W, 1'b1};
        default:            tivb_wide = {SLOT_NONE, 1'b1};
      endcase
    end
  endfunction

  // Decode a write into one invalidation operation
  always @* begin
    op_go     = 1'b0;
    op_ctx    = `TIVB_CTX_HYP;
    op_last   = 1'b0;
    op_va     = 64'h0;
    op_narrow = 1'b0;
    mapped    = 1'b1;
    wide_code = tivb_wide(PADDR_I);
    wide_sel  = wide_code[2:1];
    wide_hi   = wide_code[0];
    case (PADDR_I)
      `TIVB_OFF_SMVAL_LO, `TIVB_OFF_SMVAL_HI,
      `TIVB_OFF_SMVA_LO, `TIVB_OFF_SMVA_HI: begin
        mapped  = mon_ok;
        op_ctx  = `TIVB_CTX_SECURE_MONITOR_CONTEXT;
        op_last = (wide_sel == SLOT_SMVAL);
      end
      `TIVB_OFF_HVA_W_LO, `TIVB_OFF_HVA_W_HI: begin
        mapped    = hw_ok;
        op_narrow = NARROW_SCHEME && !cfg_q[`TIVB_CFG_NARROW];
      end
      `TIVB_OFF_HVA_N: begin
        mapped = 1'b1;
        op_go  = wr && NARROW_SCHEME;
        op_va  = {{32{1'b0}},
                  PWDATA_I[31:`TIVB_PAGE_LSB],
                  {`TIVB_PAGE_LSB{1'b0}}};
      end
      `TIVB_OFF_CFG, `TIVB_OFF_STAT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    if (wr && mapped && wide_sel != SLOT_NONE) begin
      if (!wide_hi)
        op_va = tivb_mk_va({12'h000, PWDATA_I}, op_narrow);
      else if (lo_pend_q[wide_sel])               // Second half of a pair
        op_va = tivb_mk_va({PWDATA_I[`TIVB_HI_FLD_MSB:0], lo_q[wide_sel]},
                           op_narrow);
      op_go = !wide_hi || lo_pend_q[wide_sel];
    end
  end

  genvar g;
  generate
    for (g = 0; g < `TIVB_ENTRIES; g = g + 1) begin : g_cmp
      wire [63:0] diff = tag_va_q[g] ^ op_va;
      wire ign = cfg_q[`TIVB_CFG_GRAN64];
      wire va_eq = (diff[63:`TIVB_G64_MSB+1] == 48'h0) &&
                   (ign || diff[`TIVB_G64_MSB:`TIVB_PAGE_LSB] == 4'h0);
      // Exact match save bits 15:12 under 64KB granule: no over-invalidation, locked entries stay
      assign hit[g] = VALID_O[g] && !tag_lock_q[g] && va_eq &&
                      tag_ctx_q[g] == op_ctx &&
                      (!op_last || tag_last_q[g]);
    end
  endgenerate

  // Only the configuration and count words read back; the rest read zero
  function [31:0] tivb_rdata;
    input [11:0] a;
    input [1:0]  cfg;
    input [7:0]  cnt;
    begin
      case (a)
        `TIVB_OFF_CFG:  tivb_rdata = {30'h0, cfg};
        `TIVB_OFF_STAT: tivb_rdata = {24'h0, cnt};
        default:        tivb_rdata = 32'h0;
      endcase
    end
  endfunction

  integer i;
  integer j;

  // Answer: one wait state, then data and error stand with ready
  always @(posedge CLK_SYS_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q     <= 1'b0;
      PRDATA_O  <= 32'h0;
      PSLVERR_O <= 1'b0;
    end else begin
      ack_q     <= acc_first;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0;
      if (acc_first && !mapped)
        PSLVERR_O <= 1'b1;
      if (rd)
        PRDATA_O <= tivb_rdata(PADDR_I, cfg_q, stat_q);
    end
  end

  // Halves pair across busy-bus transfers, reads between allowed; an idle bus or any
  // other write drops a waiting low word, so a lone upper word is void
  always @(posedge CLK_SYS_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lo_pend_q <= 3'h0;
      for (i = 0; i < 3; i = i + 1)
        lo_q[i] <= 32'h0;
    end else begin
      if (wr || !PSEL_I)
        lo_pend_q <= 3'h0;
      if (wr && mapped && wide_sel != SLOT_NONE && !wide_hi) begin
        lo_pend_q[wide_sel] <= 1'b1;
        lo_q[wide_sel]      <= PWDATA_I;
      end
    end
  end

  always @(posedge CLK_SYS_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_q   <= `TIVB_CFG_RESET;
      stat_q  <= 8'h00;
      INVAL_O <= 1'b0;
    end else begin
      INVAL_O <= op_go;
      if (wr && PADDR_I == `TIVB_OFF_CFG)
        cfg_q <= PWDATA_I[`TIVB_CFG_NARROW:`TIVB_CFG_GRAN64];
      // Count wraps; it only shows software that operations ran
      if (op_go)
        stat_q <= stat_q + 8'h01;
    end
  end

  // Fill after invalidation so a same-cycle fill survives
  always @(posedge CLK_SYS_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      VALID_O    <= {`TIVB_ENTRIES{1'b0}};
      tag_last_q <= {`TIVB_ENTRIES{1'b0}};
      tag_lock_q <= {`TIVB_ENTRIES{1'b0}};
      for (j = 0; j < `TIVB_ENTRIES; j = j + 1) begin
        tag_va_q[j]  <= 64'h0;
        tag_ctx_q[j] <= 2'h0;
      end
    end else begin
      VALID_O <= VALID_O & ~(hit & {`TIVB_ENTRIES{op_go}});
      if (FILL_I) begin
        VALID_O[FILL_IDX_I]    <= 1'b1;
        tag_va_q[FILL_IDX_I]   <= FILL_VA_I;
        tag_ctx_q[FILL_IDX_I]  <= FILL_CTX_I;
        tag_last_q[FILL_IDX_I] <= FILL_LAST_I;
        tag_lock_q[FILL_IDX_I] <= FILL_LOCK_I;
      end
    end
  end
endmodule

// ===== bench/tivb_top_sva.sv
`timescale 1ns/1ps
`include "tivb_map.vh"
module tivb_chk (
  input wire        CLK_SYS_I, // Clock
  input wire        ARST_N_I,  // Reset, low
  input wire        PSEL_I,    // Select
  input wire        PENABLE_I, // Enable
  input wire        PWRITE_I,  // Direction
  input wire [11:0] PADDR_I,   // Address
  input wire        PREADY_O,  // Ready
  input wire [31:0] PRDATA_O,  // Read data
  input wire        PSLVERR_O, // Error
  input wire [15:0] VALID_O,   // Entry valid
  input wire        INVAL_O    // Invalidate pulse
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!ARST_N_I);
  wire acc = PSEL_I & PENABLE_I;
  wire wr  = acc & PWRITE_I & PREADY_O;
  chk_ready_high:
    assert property (acc && !PREADY_O |=> PREADY_O)
      else $error("ready late");
  chk_inval_cause:
    assert property (INVAL_O |-> $past(wr)) else $error("stray pulse");
  chk_hi_alone:
    assert property (wr && PADDR_I == `TIVB_OFF_SMVA_HI && !$past(wr, 3)
      |=> !INVAL_O) else $error("upper word acted");
  chk_lo_trig:
    assert property (wr && PADDR_I == `TIVB_OFF_SMVA_LO |=> INVAL_O)
      else $error("low word idle");
  chk_drop_inval:
    assert property (|($past(VALID_O) & ~VALID_O) |-> INVAL_O)
      else $error("entry lost");
  chk_read_zero:
    assert property (acc && PREADY_O && !PWRITE_I &&
      PADDR_I < `TIVB_OFF_CFG |-> PRDATA_O == 32'h0)
      else $error("read not zero");
  chk_unmapped_err:
    assert property (acc && PREADY_O && PADDR_I == 12'h014 |-> PSLVERR_O)
      else $error("no error");
  chk_mapped_ok:
    assert property (acc && PREADY_O && PADDR_I < 12'h014 |-> !PSLVERR_O)
      else $error("false error");
endmodule
bind tivb_top tivb_chk u_chk (.CLK_SYS_I, .ARST_N_I, .PSEL_I, .PENABLE_I,
  .PWRITE_I, .PADDR_I, .PREADY_O, .PRDATA_O, .PSLVERR_O, .VALID_O, .INVAL_O);

// ===== bench/tlb_invalidate_by_va_test.sv
`timescale 1ns/1ps
`include "tivb_map.vh"
module tlb_invalidate_by_va_test;
  typedef struct {logic [1:0] md; logic [11:0] a; logic [31:0] d, h;
    logic [63:0] va; logic [1:0] cx; logic l, k, clr;} tivb_row_t;
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
  logic        fill = 0, lst = 0, lk = 0, er;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, rd;
  logic [63:0] fva = 0;
  logic [1:0]  fcx = 0;
  logic [15:0] vd;
  wire         rdy, inv, slv;
  wire [31:0]  prd;
  wire [15:0]  vo;
  int          err_count = 0, n_checks = 0;
  // Entry rows: mode 0 low, 1 low+upper, 2 upper alone
  tivb_row_t rows[8] = '{
    '{0, 'h000, 'h0001_2345, 0, 'h1234_5000, 1, 1, 0, 1},
    '{0, 'h000, 'h0001_2345, 0, 'h1234_5000, 1, 0, 0, 0},
    '{0, 'h008, 'h0001_2345, 0, 'h1234_5000, 1, 0, 0, 1},
    '{0, 'h008, 'h0001_2345, 0, 'h1234_5000, 1, 0, 1, 0},
    '{0, 'h010, 'h1234_5fff, 0, 'h1234_5000, 2, 0, 0, 1},
    '{0, 'h018, 'h0001_2345, 0, 'h1234_5000, 2, 0, 0, 1},
    '{1, 'h018, 'h0001_2345, 'hfff0_08ab, 64'hff8a_b000_1234_5000, 2, 1, 0, 1},
    '{2, 'h00c, 0, 0, 0, 1, 0, 0, 0}};
  always #20 clk = ~clk;
  tivb_top dut (.CLK_SYS_I(clk), .ARST_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd),
    .PREADY_O(rdy), .PRDATA_O(prd), .PSLVERR_O(slv), .FILL_I(fill),
    .FILL_VA_I(fva), .FILL_CTX_I(fcx), .FILL_LAST_I(lst), .FILL_LOCK_I(lk),
    .FILL_IDX_I(4'h0), .VALID_O(vo), .INVAL_O(inv));
  task cmp(input logic [31:0] g, e, input string m);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch t=%0t %s", $time, m);
    end
  endtask
  // Ends on the ready edge, answer taken there; a second call follows
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk) pen <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    {rd, er} = {prd, slv};
  endtask
  // Entry bits change at the ready edge; look once they settle
  task idle;
    psel <= 0; pen <= 0;
    @(negedge clk) vd = vo;
    @(posedge clk);
  endtask
  task fil(input logic [63:0] v, input logic [1:0] c, input logic l, k);
    fill <= 1; fva <= v; fcx <= c; lst <= l; lk <= k;
    @(posedge clk) fill <= 0;
    @(posedge clk);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    cmp({16'h0, vo}, 0, "reset valid");
    apb(1, `TIVB_OFF_CFG, 32'h2);
    idle;
    foreach (rows[i]) begin
      fil(rows[i].va, rows[i].cx, rows[i].l, rows[i].k);
      if (rows[i].md != 2) apb(1, rows[i].a, rows[i].d);
      if (rows[i].md != 0) apb(1, rows[i].a | 12'h004, rows[i].h);
      idle;
      cmp(vd[0], !rows[i].clr, "row entry");
      $display("row %0d done", i);
    end
    apb(1, `TIVB_OFF_CFG, 32'h3);
    idle;
    fil(64'h1234_5000, 1, 0, 0);
    apb(1, `TIVB_OFF_SMVA_LO, 32'h0001_234a);
    idle;
    cmp(vd[0], 0, "granule entry");
    apb(1, `TIVB_OFF_CFG, 32'h0);
    idle;
    fil(64'h1234_5000, 2, 0, 0);
    apb(1, `TIVB_OFF_HVA_W_LO, 32'habc1_2345);
    apb(1, `TIVB_OFF_HVA_W_HI, 32'h0000_0123);
    idle;
    cmp(vd[0], 0, "narrow entry");
    apb(0, `TIVB_OFF_SMVAL_LO, 0);
    idle;
    cmp({rd[31:1], rd[0] | er}, 0, "read back");
    apb(0, 12'h014, 0);
    idle;
    cmp(er, 1, "unmapped");
    $display("hand tests done");
    tally_and_finish;
  end
  initial begin
    #50us;
    err_count++;
    tally_and_finish;
  end
endmodule
